// >>> rtl/ssp_framer.sv
// Purpose: Serial address, early-stop and line-mode packet receiver
// Assumes: Request fields loaded over APB before a start
// Notes: One-wait-state APB answer one cycle after the access phase begins
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.svh"

module ssp_framer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic serial_enable_line,
    input wire logic sideband_control_line,
    output logic octbyte_valid,
    output logic [32:0] octbyte_addr,
    output logic [4:0] octbyte_index,
    output logic octbyte_is_read,
    output logic xfer_done,
    output logic [1:0] mode,
    output logic device_in_reset
);

    logic even_tick;
    logic odd_tick;
    logic en_bit;
    logic ctl_bit;

    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic acc_start;
    logic wr_fire;

    ssp_pkg::ssp_cmd_t cmd_q;
    logic [24:0] adr_hi_q;
    logic [7:0] adr_lo_q;
    logic [4:0] count_q;

    ssp_pkg::ssp_xfer_t xfer_q;
    logic [4:0] slot_q;
    logic [2:0] tick_q;
    logic [7:0] serial_low_address_sh_q;
    logic [7:0] sctl_sh_q;
    logic [7:0] serial_low_address_full;
    logic [7:0] sctl_full;
    logic tick_take;
    logic slot_end;
    logic stop_now;
    logic last_slot;
    logic is_mem;
    logic is_nsq;
    logic start_req;
    logic [2:0] wr_cmd;
    logic [32:0] seq_addr;

    logic octbyte_valid_q;
    logic [32:0] octbyte_addr_q;
    logic [4:0] octbyte_index_q;
    logic octbyte_is_read_q;
    logic xfer_done_q;
    logic [5:0] xfer_cnt_q;
    logic term_q;
    logic frame_err_q;

    logic pair_q;
    logic pair_bit_q;
    logic code_valid;
    logic code00;
    logic code11;
    logic code11_q;
    logic [3:0] zeros_q;
    logic [8:0] ones_q;
    ssp_pkg::ssp_mode_t mode_q;

    ssp_tick_rx u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .link_clk(link_clk),
        .enable_pin(serial_enable_line),
        .control_pin(sideband_control_line),
        .even_tick(even_tick),
        .odd_tick(odd_tick),
        .enable_bit(en_bit),
        .control_bit(ctl_bit)
    );

    // ============================================================
    // APB slave
    assign acc_start = psel & penable & ~pready_q;
    assign wr_fire = psel & penable & pready_q & pwrite;

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (paddr)
            `SSP_CTRL_OFS: rd_mux[`SSP_CTRL_CMD_LSB +: 3] = cmd_q;
            `SSP_ADDR_HI_OFS: rd_mux[24:0] = adr_hi_q;
            `SSP_ADDR_LO_OFS: begin
                rd_mux[7:0] = adr_lo_q;
                rd_mux[`SSP_LO_COUNT_LSB +: 5] = count_q;
            end
            `SSP_STATUS_OFS: begin
                rd_mux[`SSP_ST_BUSY_BIT] = (xfer_q != ssp_pkg::SSP_XF_IDLE);
                rd_mux[`SSP_ST_FRAME_ERR_BIT] = frame_err_q;
                rd_mux[`SSP_ST_TERM_BIT] = term_q;
                rd_mux[`SSP_ST_MODE_LSB +: 2] = mode_q;
                rd_mux[`SSP_ST_XCNT_LSB +: 6] = xfer_cnt_q;
                rd_mux[`SSP_ST_ZEROS_LSB +: 4] = zeros_q;
                rd_mux[`SSP_ST_ONES_LSB +: 8] =
                    ones_q[8] ? 8'hff : ones_q[7:0];
                rd_mux[`SSP_ST_LONG_BIT] = ones_q[8];
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= acc_start;
            if (acc_start) begin
                prdata_q <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_q <= (paddr != `SSP_CTRL_OFS) &&
                    (paddr != `SSP_ADDR_HI_OFS) &&
                    (paddr != `SSP_ADDR_LO_OFS) &&
                    (paddr != `SSP_STATUS_OFS);
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    assign wr_cmd = pwdata[`SSP_CTRL_CMD_LSB +: 3];
    // Starts outside active mode or while busy are dropped
    assign start_req = wr_fire && (paddr == `SSP_CTRL_OFS) &&
        pwdata[`SSP_CTRL_START_BIT] && (wr_cmd != 3'h7) &&
        (xfer_q == ssp_pkg::SSP_XF_IDLE) &&
        (mode_q == ssp_pkg::SSP_MD_ACTIVE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= ssp_pkg::SSP_CMD_SEQ_READ;
            adr_hi_q <= `SSP_ADDR_HI_RST;
            adr_lo_q <= `SSP_ADDR_LO_RST;
            count_q <= `SSP_COUNT_RST;
        end else if (wr_fire) begin
            if (start_req) begin
                cmd_q <= ssp_pkg::ssp_cmd_t'(wr_cmd);
            end
            if (paddr == `SSP_ADDR_HI_OFS) begin
                adr_hi_q <= pwdata[24:0];
            end
            if (paddr == `SSP_ADDR_LO_OFS) begin
                adr_lo_q <= pwdata[7:0];
                count_q <= pwdata[`SSP_LO_COUNT_LSB +: 5];
            end
        end
    end

    // ============================================================
    // Serial address and early-stop reception
    assign is_mem = (cmd_q != ssp_pkg::SSP_CMD_REG_READ) &&
        (cmd_q != ssp_pkg::SSP_CMD_REG_WRITE);
    assign is_nsq = (cmd_q == ssp_pkg::SSP_CMD_NSQ_READ) ||
        (cmd_q == ssp_pkg::SSP_CMD_NSQ_WRITE) ||
        (cmd_q == ssp_pkg::SSP_CMD_NSQ_MWRITE);
    assign tick_take = ((xfer_q == ssp_pkg::SSP_XF_WAIT) && even_tick) ||
        ((xfer_q == ssp_pkg::SSP_XF_RUN) && (even_tick || odd_tick));
    // Bit 3 arrives first, so shift right: bit 10 lands on top
    assign serial_low_address_full = {en_bit, serial_low_address_sh_q[7:1]};
    assign sctl_full = {ctl_bit, sctl_sh_q[7:1]};
    assign slot_end = (xfer_q == ssp_pkg::SSP_XF_RUN) && odd_tick &&
        (tick_q == `SSP_SLOT_LAST_TICK);
    // Only bit five acts; one, three and seven never looked at
    assign stop_now = slot_end && is_mem &&
        sctl_full[`SSP_STOP_BIT];
    assign last_slot = (slot_q == count_q) || !is_mem;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_q <= ssp_pkg::SSP_XF_IDLE;
            slot_q <= 5'h00;
            tick_q <= 3'h0;
            serial_low_address_sh_q <= 8'h00;
            sctl_sh_q <= 8'h00;
        end else if (mode_q == ssp_pkg::SSP_MD_RESET) begin
            xfer_q <= ssp_pkg::SSP_XF_IDLE;
        end else begin
            if (tick_take) begin
                serial_low_address_sh_q <= serial_low_address_full;
                sctl_sh_q <= sctl_full;
                tick_q <= tick_q + 3'h1;
            end
            unique case (xfer_q)
                ssp_pkg::SSP_XF_IDLE: begin
                    if (start_req) begin
                        xfer_q <= ssp_pkg::SSP_XF_WAIT;
                        slot_q <= 5'h00;
                        tick_q <= 3'h0;
                    end
                end
                ssp_pkg::SSP_XF_WAIT: begin
                    if (even_tick) begin
                        xfer_q <= ssp_pkg::SSP_XF_RUN;
                    end
                end
                ssp_pkg::SSP_XF_RUN: begin
                    if (slot_end) begin
                        if (stop_now || last_slot) begin
                            xfer_q <= ssp_pkg::SSP_XF_IDLE;
                        end else begin
                            slot_q <= slot_q + 5'h01;
                        end
                    end
                end
                default: xfer_q <= ssp_pkg::SSP_XF_IDLE;
            endcase
        end
    end

    // ============================================================
    // Octbyte issue
    assign seq_addr = {adr_hi_q, adr_lo_q} + {28'h0000000, slot_q};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            octbyte_valid_q <= 1'b0;
            octbyte_addr_q <= 33'h000000000;
            octbyte_index_q <= 5'h00;
            octbyte_is_read_q <= 1'b0;
        end else begin
            // A stop withholds this slot's octbyte entirely
            octbyte_valid_q <= slot_end && !stop_now;
            if (slot_end && !stop_now) begin
                octbyte_index_q <= slot_q;
                octbyte_is_read_q <= (cmd_q == ssp_pkg::SSP_CMD_SEQ_READ) ||
                    (cmd_q == ssp_pkg::SSP_CMD_NSQ_READ) ||
                    (cmd_q == ssp_pkg::SSP_CMD_REG_READ);
                if (slot_q == 5'h00) begin
                    octbyte_addr_q <= {adr_hi_q, adr_lo_q};
                end else if (is_nsq) begin
                    octbyte_addr_q <= {adr_hi_q, serial_low_address_full};
                end else begin
                    octbyte_addr_q <= seq_addr;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_done_q <= 1'b0;
            xfer_cnt_q <= 6'h00;
            term_q <= 1'b0;
        end else begin
            xfer_done_q <= slot_end && (stop_now || last_slot);
            if (start_req) begin
                xfer_cnt_q <= 6'h00;
                term_q <= 1'b0;
            end else begin
                if (slot_end && !stop_now) begin
                    xfer_cnt_q <= xfer_cnt_q + 6'h01;
                end
                if (stop_now) begin
                    term_q <= 1'b1;
                end
            end
        end
    end

    // Even-tick stop bit high would look like a request start bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_err_q <= 1'b0;
        end else if (tick_take && even_tick && is_mem && ctl_bit) begin
            frame_err_q <= 1'b1;
        end else if (wr_fire && (paddr == `SSP_STATUS_OFS) &&
                     pwdata[`SSP_ST_FRAME_ERR_BIT]) begin
            frame_err_q <= 1'b0;
        end
    end

    // ============================================================
    // Line-mode packets and run counters
    assign code_valid = odd_tick && pair_q &&
        (xfer_q == ssp_pkg::SSP_XF_IDLE);
    assign code00 = code_valid && !pair_bit_q && !en_bit;
    assign code11 = code_valid && pair_bit_q && en_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_q <= 1'b0;
            pair_bit_q <= 1'b0;
        end else if (even_tick) begin
            pair_q <= 1'b1;
            pair_bit_q <= en_bit;
        end else if (odd_tick) begin
            pair_q <= 1'b0;
        end
    end

    // Mixed codes 01 and 10 leave both counters alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zeros_q <= 4'h0;
            ones_q <= 9'h000;
            code11_q <= 1'b0;
        end else begin
            code11_q <= code11;
            if (code00) begin
                ones_q <= 9'h000;
                if (zeros_q != `SSP_ZEROS_MAX) begin
                    zeros_q <= zeros_q + 4'h1;
                end
            end else if (code11) begin
                zeros_q <= 4'h0;
                if (ones_q != `SSP_ONES_MAX) begin
                    ones_q <= ones_q + 9'h001;
                end
            end
        end
    end

    // ============================================================
    // Operating mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= ssp_pkg::SSP_MD_STANDBY;
        end else if (ones_q >= `SSP_RESET_ENTRY) begin
            mode_q <= ssp_pkg::SSP_MD_RESET;
        end else begin
            unique case (mode_q)
                ssp_pkg::SSP_MD_RESET: begin
                    if (ones_q < `SSP_WAKE_MIN) begin
                        mode_q <= ssp_pkg::SSP_MD_ACTIVE;
                    end
                end
                ssp_pkg::SSP_MD_STANDBY: begin
                    // Woken by a fresh 11 packet, not a stale count
                    if (code11_q && ones_q >= `SSP_WAKE_MIN) begin
                        mode_q <= ssp_pkg::SSP_MD_ACTIVE;
                    end
                end
                ssp_pkg::SSP_MD_ACTIVE: begin
                    if (xfer_done_q) begin
                        mode_q <= ssp_pkg::SSP_MD_STANDBY;
                    end else if (xfer_q == ssp_pkg::SSP_XF_IDLE &&
                                 zeros_q >= `SSP_WAKE_HOLD) begin
                        mode_q <= ssp_pkg::SSP_MD_STANDBY;
                    end
                end
                default: mode_q <= ssp_pkg::SSP_MD_STANDBY;
            endcase
        end
    end

    // ============================================================
    // Outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign octbyte_valid = octbyte_valid_q;
    assign octbyte_addr = octbyte_addr_q;
    assign octbyte_index = octbyte_index_q;
    assign octbyte_is_read = octbyte_is_read_q;
    assign xfer_done = xfer_done_q;
    assign mode = mode_q;
    assign device_in_reset = (mode_q == ssp_pkg::SSP_MD_RESET);

    // ============================================================
    // Checks
    a_stop_drops_octbyte: assert property (@(posedge pclk)
        disable iff (!presetn) stop_now |=> !octbyte_valid_q && xfer_done_q)
        else $error("stopped slot still issued an octbyte");
    a_index_in_range: assert property (@(posedge pclk)
        disable iff (!presetn) octbyte_valid_q |-> octbyte_index_q <= count_q)
        else $error("octbyte index beyond request count");
    a_first_low_addr: assert property (@(posedge pclk)
        disable iff (!presetn)
        octbyte_valid_q && octbyte_index_q == 5'h00
        |-> octbyte_addr_q == {adr_hi_q, adr_lo_q})
        else $error("first octbyte address not from request");
    a_serial_low_addr: assert property (@(posedge pclk)
        disable iff (!presetn)
        slot_end && !stop_now && slot_q != 5'h00 && is_nsq
        |=> octbyte_addr_q[7:0] == $past(serial_low_address_full)
            && octbyte_addr_q[32:8] == adr_hi_q)
        else $error("serial low address not applied");
    a_stop_at_boundary: assert property (@(posedge pclk)
        disable iff (!presetn)
        $fell(xfer_q == ssp_pkg::SSP_XF_RUN) && mode_q != ssp_pkg::SSP_MD_RESET
        |-> $past(slot_end))
        else $error("transfer ended off a slot boundary");
    a_zeros_code: assert property (@(posedge pclk)
        disable iff (!presetn) code00 && zeros_q < 4'h5
        |=> ones_q == 9'h000 && zeros_q == $past(zeros_q) + 4'h1)
        else $error("code 00 did not update run counters");
    a_ones_code: assert property (@(posedge pclk)
        disable iff (!presetn) code11 && ones_q < 9'h010
        |=> zeros_q == 4'h0 && ones_q == $past(ones_q) + 9'h001)
        else $error("code 11 did not update run counters");
    a_ones_saturate: assert property (@(posedge pclk)
        disable iff (!presetn) ones_q == `SSP_ONES_MAX && !code00
        |=> ones_q == `SSP_ONES_MAX)
        else $error("ones run counter wrapped");
    a_reset_entry: assert property (@(posedge pclk)
        disable iff (!presetn) ones_q >= 9'h110 |=> device_in_reset)
        else $error("long ones run did not enter reset mode");
    a_reset_exit: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_q == ssp_pkg::SSP_MD_RESET && ones_q == 9'h000
        |=> mode_q == ssp_pkg::SSP_MD_ACTIVE)
        else $error("reset mode not left after code 00");
    a_wake_standby: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_q == ssp_pkg::SSP_MD_STANDBY && code11
        |-> ##[1:2] mode_q == ssp_pkg::SSP_MD_ACTIVE)
        else $error("ones packet did not wake from standby");
    a_hold_expiry: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_q == ssp_pkg::SSP_MD_ACTIVE && xfer_q == ssp_pkg::SSP_XF_IDLE
        && zeros_q >= 4'ha && ones_q < 9'h110
        |=> mode_q == ssp_pkg::SSP_MD_STANDBY)
        else $error("active mode held past the wake limit");

endmodule

`default_nettype wire

// >>> rtl/ssp_pkg.sv
// Purpose: Types shared by the sideband packet logic
// Assumes: Nothing
// Notes: Constants live in ssp_regs.svh
package ssp_pkg;

    typedef enum logic [2:0] {
        SSP_CMD_SEQ_READ,
        SSP_CMD_SEQ_WRITE,
        SSP_CMD_NSQ_READ,
        SSP_CMD_NSQ_WRITE,
        SSP_CMD_NSQ_MWRITE,
        SSP_CMD_REG_READ,
        SSP_CMD_REG_WRITE
    } ssp_cmd_t;

    typedef enum logic [1:0] {
        SSP_MD_RESET,
        SSP_MD_STANDBY,
        SSP_MD_ACTIVE
    } ssp_mode_t;

    typedef enum logic [1:0] {
        SSP_XF_IDLE,
        SSP_XF_WAIT,
        SSP_XF_RUN
    } ssp_xfer_t;

endpackage

// >>> rtl/ssp_regs.svh
// Purpose: Offsets, field positions, reset values and thresholds
// Assumes: APB byte addresses, 32-bit words
// Notes: Definitions only
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// ============================================================
// Register offsets
`define SSP_CTRL_OFS 8'h00
`define SSP_ADDR_HI_OFS 8'h04
`define SSP_ADDR_LO_OFS 8'h08
`define SSP_STATUS_OFS 8'h0c

// ============================================================
// Field positions
`define SSP_CTRL_START_BIT 0
`define SSP_CTRL_CMD_LSB 1
`define SSP_LO_COUNT_LSB 8
`define SSP_ST_BUSY_BIT 0
`define SSP_ST_FRAME_ERR_BIT 1
`define SSP_ST_TERM_BIT 2
`define SSP_ST_MODE_LSB 3
`define SSP_ST_XCNT_LSB 5
`define SSP_ST_ZEROS_LSB 11
`define SSP_ST_ONES_LSB 16
`define SSP_ST_LONG_BIT 24
`define SSP_STOP_BIT 5

// ============================================================
// Reset values and counts
`define SSP_ADDR_HI_RST 25'h0000000
`define SSP_ADDR_LO_RST 8'h00
`define SSP_COUNT_RST 5'h00
`define SSP_SLOT_LAST_TICK 3'h7
`define SSP_ZEROS_MAX 4'hf
`define SSP_ONES_MAX 9'h1ff
`define SSP_WAKE_MIN 9'h001
`define SSP_WAKE_MAX 9'h004
`define SSP_RESET_ENTRY 9'h110
`define SSP_WAKE_HOLD 4'ha

`endif

// >>> rtl/ssp_tick_rx.sv
// Purpose: Brings link clock and sideband pins into pclk, finds ticks
// Assumes: Link clock well below pclk/4
// Notes: Rising link edge is the even tick, falling edge the odd tick
`timescale 1ns/1ps
`default_nettype none

module ssp_tick_rx (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_clk,
    input wire logic enable_pin,
    input wire logic control_pin,
    output logic even_tick,
    output logic odd_tick,
    output logic enable_bit,
    output logic control_bit
);

    logic [1:0] clk_sync_q;
    logic [1:0] en_sync_q;
    logic [1:0] ctl_sync_q;
    logic clk_prev_q;

    // ============================================================
    // Synchronisers and edge finder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync_q <= 2'h0;
            en_sync_q <= 2'h0;
            ctl_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
            even_tick <= 1'b0;
            odd_tick <= 1'b0;
            enable_bit <= 1'b0;
            control_bit <= 1'b0;
        end else begin
            clk_sync_q <= {clk_sync_q[0], link_clk};
            en_sync_q <= {en_sync_q[0], enable_pin};
            ctl_sync_q <= {ctl_sync_q[0], control_pin};
            clk_prev_q <= clk_sync_q[1];
            even_tick <= clk_sync_q[1] & ~clk_prev_q;
            odd_tick <= ~clk_sync_q[1] & clk_prev_q;
            // Pins equally delayed, so bit aligns with its edge
            enable_bit <= en_sync_q[1];
            control_bit <= ctl_sync_q[1];
        end
    end

endmodule

`default_nettype wire

// >>> test/ssp_ctrl_model.sv
// Purpose: Initiating controller model driving the sideband pins
// Assumes: Link clock of 32 ns, stopped low between frames
// Notes: Lines idle low as if pulled down after each frame
`timescale 1ns/1ps
`default_nettype none
module ssp_ctrl_model (
    output var logic link_clk = 1'b0,
    output var logic enable_pin = 1'b0,
    output var logic control_pin = 1'b0
);
    // ====
    // Frame sender
    // Data moves mid half-period, so both sides of each edge are clean
    task automatic xmit(input int n, input logic [7:0] en,
                        input logic [7:0] ctl);
        for (int i = 0; i < n; i++) begin
            enable_pin <= en[i];
            control_pin <= ctl[i] & i[0];
            #8 link_clk <= ~link_clk;
            #8;
        end
        enable_pin <= 1'b0;
        control_pin <= 1'b0;
        // Idle gap keeps the next frame's first bit off this release
        #8;
    endtask
endmodule
`default_nettype wire

// >>> test/test_ssp_framer.sv
// Purpose: Self-checking bench for the sideband packet logic
// Assumes: APB answer after one wait state
// Notes: Fixed waits cover the short pin-to-output pipeline
`timescale 1ns/1ps
`default_nettype none
module test_ssp_framer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic lclk, sen, sctl, ob_v, ob_rd, done, in_rst;
    logic [32:0] ob_a;
    logic [4:0] ob_i;
    logic [1:0] mode;
    logic [38:0] got[$];
    logic [24:0] hi = 25'h0abcdef;
    int n_fail, cmp_count, n_done;
    ssp_framer i_ssp_framer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clk(lclk), .serial_enable_line(sen),
        .sideband_control_line(sctl), .octbyte_valid(ob_v),
        .octbyte_addr(ob_a), .octbyte_index(ob_i), .octbyte_is_read(ob_rd),
        .xfer_done(done), .mode(mode), .device_in_reset(in_rst));
    ssp_ctrl_model i_ssp_ctrl_model (.link_clk(lclk), .enable_pin(sen),
        .control_pin(sctl));
    // ====
    // Clock, capture and watchdog
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (ob_v === 1'b1) got.push_back({ob_rd, ob_i, ob_a});
        if (done === 1'b1) n_done++;
    end
    initial begin
        #100us;
        n_fail++;
        conclude();
    end
    // ====
    // Tasks
    task automatic check(input logic [38:0] g, input logic [38:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sl(input logic [7:0] a, input logic [7:0] c);
        i_ssp_ctrl_model.xmit(8, a, c);
    endtask
    task automatic pk(input int n, input logic [1:0] c);
        repeat (n) i_ssp_ctrl_model.xmit(2, {6'h00, c}, 8'h00);
        repeat (8) @(posedge pclk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ====
    // Tests
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(0, 8'h0c, 32'h0);
        check(rd, 32'h8);
        apb(0, 8'h10, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        pk(1, 2'b11);
        apb(0, 8'h0c, 32'h0);
        check(rd, 32'h00010010);
        $display("test reset and wake done");
        apb(1, 8'h04, {7'h00, hi});
        apb(1, 8'h08, 32'h0210);
        apb(1, 8'h00, 32'h5);
        sl(8'h00, 8'h00);
        sl(8'h55, 8'h00);
        sl(8'haa, 8'h00);
        repeat (8) @(posedge pclk);
        check(got.size(), 3);
        check(got[0], {1'b1, 5'd0, hi, 8'h10});
        check(got[1], {1'b1, 5'd1, hi, 8'h55});
        check(got[2], {1'b1, 5'd2, hi, 8'haa});
        check(n_done, 1);
        check(mode, 2'd1);
        got.delete();
        $display("test serial address done");
        pk(1, 2'b11);
        apb(1, 8'h08, 32'h0320);
        apb(1, 8'h00, 32'h1);
        sl(8'h00, 8'h8a);
        sl(8'h00, 8'h00);
        sl(8'h00, 8'h20);
        repeat (8) @(posedge pclk);
        check(got.size(), 2);
        check(got[1], {1'b1, 5'd1, hi, 8'h21});
        check(n_done, 2);
        apb(0, 8'h0c, 32'h0);
        check({rd[10:5], rd[2], rd[4:3]}, {6'd2, 1'b1, 2'd1});
        $display("test early stop done");
        got.delete();
        pk(1, 2'b11);
        apb(1, 8'h00, 32'hd);
        sl(8'h00, 8'h20);
        repeat (8) @(posedge pclk);
        check(got.size(), 1);
        check(got[0], {1'b0, 5'd0, hi, 8'h20});
        check(n_done, 3);
        $display("test register command done");
        pk(16, 2'b00);
        apb(0, 8'h0c, 32'h0);
        check({rd[23:16], rd[14:11]}, {8'h00, 4'hf});
        pk(271, 2'b11);
        check(in_rst, 1'b0);
        pk(1, 2'b11);
        check({in_rst, mode}, {1'b1, 2'd0});
        pk(240, 2'b11);
        check({in_rst, mode}, {1'b1, 2'd0});
        apb(0, 8'h0c, 32'h0);
        check({rd[24:16], rd[14:11]}, {9'h1ff, 4'h0});
        pk(1, 2'b00);
        check(mode, 2'd2);
        pk(8, 2'b00);
        check(mode, 2'd2);
        pk(1, 2'b00);
        check(mode, 2'd1);
        $display("test line mode done");
        conclude();
    end
endmodule
`default_nettype wire
